/* File: rtl/cesi_map.svh */
// Register offsets, field positions, reset values and widths of the clock event status block.
`ifndef CESI_MAP_SVH
`define CESI_MAP_SVH

// Printed offsets are register indices; byte address is four times the index.
`define CESI_IDX_INPUT_FAIL_FLAGS   8'h02
`define CESI_IDX_LOOP_EVENT_FLAGS   8'h03
`define CESI_IDX_INPUT_FAIL_EN      8'h04
`define CESI_IDX_LOOP_EVENT_EN      8'h05
`define CESI_IDX_MON_FLAGS_HI       8'h06
`define CESI_IDX_MON_FLAGS_LO       8'h07
`define CESI_IDX_MON_MASK_HI        8'h08
`define CESI_IDX_MON_MASK_LO        8'h09
`define CESI_IDX_PIN_SELECT         8'h0a

`define CESI_RST_FLAGS              8'h00
`define CESI_RST_IRQ_EN             8'h00
`define CESI_RST_MON_MASK           8'h66
`define CESI_RST_PIN_SELECT         16'h0000

`define CESI_BIT_LOOP_A_HOLD        0
`define CESI_BIT_LOOP_A_UNLOCK      1
`define CESI_BIT_LOOP_B_HOLD        2
`define CESI_BIT_LOOP_B_UNLOCK      3

`define CESI_FLD_LOST               0
`define CESI_FLD_CYCLE              1
`define CESI_FLD_FREQ               2
`define CESI_FLD_SOAK               3

`define CESI_PIN_SEL_W              4

`endif

/* File: rtl/cesi_pkg.sv */
// Types shared by the clock event status block.
package cesi_pkg;
  typedef logic [7:0]  cesi_byte_t;
  typedef logic [31:0] cesi_word_t;
  typedef logic [3:0]  cesi_nib_t;
endpackage

/* File: rtl/cesi_top.sv */
// Event status, monitor flags and interrupt request of a two-loop clock translator, behind APB.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "cesi_map.svh"

// Function
// - Loop A holdover sets flag bit 0 when its enable bit is high.
// - Loop A lock loss sets flag bit 1 when its enable bit is high.
// - Any set loop event flag drives the interrupt request high.
// - Loop B uses bits 2 and 3 for holdover and lock loss.
// - Input fail enable bits 0 to 3; zero suppresses interrupt and status.
// - Loop enable bit 0 zero blocks loop A holdover flag and interrupt.
// - Loop enable bit 1 zero blocks loop A lock-loss flag and interrupt.
// - Input 2 signal loss from a chosen pin sets monitor hi bit 0.
// - Each input's signal-loss source pin is selectable by configuration.
// - Input 2 single-cycle fault sets monitor hi bit 1.
// - Input 2 coarse frequency fault sets monitor hi bit 2.
// - Input 2 soak timer expiry sets monitor hi bit 3.
// - Monitor flags ignore every mask.
// - Input 3 faults occupy monitor hi bits 4 to 7 in same order.
// - Input fail flags 0 to 3 set on enabled failure; each raises interrupt.
// - Monitor lo register carries inputs 0 and 1 the same way.
// - Monitor mask zero keeps an indicator out of fail status only.
module cesi_top
#(
  parameter int NUM_PINS = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire cesi_pkg::cesi_word_t paddr,
  input  wire cesi_pkg::cesi_word_t pwdata,
  input  wire logic [3:0]        pstrb,
  output cesi_pkg::cesi_word_t   prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NUM_PINS-1:0] gp_pin,
  input  wire logic              loop_a_hold_ev,
  input  wire logic              loop_a_unlock_ev,
  input  wire logic              loop_b_hold_ev,
  input  wire logic              loop_b_unlock_ev,
  input  wire cesi_pkg::cesi_nib_t cycle_fault,
  input  wire cesi_pkg::cesi_nib_t freq_fault,
  input  wire cesi_pkg::cesi_nib_t soak_expired,
  output logic                   irq
);
  import cesi_pkg::*;

  // The register layout fixes the number of monitored inputs at four.
  localparam int NUM_INPUTS = 4;

  // The pin selector field is four bits wide, so at most sixteen pins can be reached.
  initial
  begin
    if (NUM_PINS < 1)
    begin
      $error("NUM_PINS must be at least one");
    end
    if (NUM_PINS > (1 << `CESI_PIN_SEL_W))
    begin
      $error("NUM_PINS exceeds the reach of the pin selector");
    end
  end

  // Both synchroniser stages live in the state; only the second stage is read by the signal-loss selection.
  typedef struct packed {
    logic [NUM_PINS-1:0] pin_s1;
    logic [NUM_PINS-1:0] pin_s2;
    cesi_nib_t  input_fail;
    cesi_nib_t  loop_flags;
    cesi_nib_t  input_fail_en;
    cesi_nib_t  loop_en;
    cesi_byte_t mon_hi;
    cesi_byte_t mon_lo;
    cesi_byte_t mask_hi;
    cesi_byte_t mask_lo;
    logic [15:0] pin_sel;
    cesi_word_t prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } cesi_state_t;

  cesi_state_t s_q;
  cesi_state_t s_d;

  logic [3:0]  lost;
  logic [15:0] mon_all;
  logic [15:0] mask_all;
  logic [3:0]  fail_now;
  logic [3:0]  fail_gated;
  logic        access;
  logic        rd;
  logic        wr;
  logic [7:0]  idx;
  logic        aligned;

  // Signal-loss inputs come from pins and are taken from the second synchroniser stage.
  // An out-of-range selector reads as no loss, so a bad setting cannot raise a flag.
  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++)
    begin : g_input
      logic [`CESI_PIN_SEL_W-1:0] sel;
      assign sel      = s_q.pin_sel[g*`CESI_PIN_SEL_W +: `CESI_PIN_SEL_W];
      assign lost[g]  = (32'(sel) < NUM_PINS) ? s_q.pin_s2[sel] : 1'b0;
      assign mon_all[g*4 + `CESI_FLD_LOST]  = lost[g];
      assign mon_all[g*4 + `CESI_FLD_CYCLE] = cycle_fault[g];
      assign mon_all[g*4 + `CESI_FLD_FREQ]  = freq_fault[g];
      assign mon_all[g*4 + `CESI_FLD_SOAK]  = soak_expired[g];
      if (g < 2)
      begin : g_lo
        assign mask_all[g*4 +: 4] = s_q.mask_lo[g*4 +: 4];
      end
      else
      begin : g_hi
        assign mask_all[g*4 +: 4] = s_q.mask_hi[(g-2)*4 +: 4];
      end
      assign fail_now[g]   = |(mon_all[g*4 +: 4] & mask_all[g*4 +: 4]);
      assign fail_gated[g] = fail_now[g] & s_q.input_fail_en[g];
    end
  endgenerate

  // An access is taken once, in its first access cycle; pready follows one edge later,
  // so every transfer carries exactly one wait state.
  assign access  = psel && penable && !s_q.pready;
  assign rd      = access && !pwrite;
  assign wr      = access && pwrite;
  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);

  always_comb
  begin
    s_d         = s_q;
    s_d.pin_s1  = gp_pin;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.pready  = access;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h00000000;

    // Clear on read comes first so that a same-cycle event still sets the bit.
    // Unmapped or misaligned accesses answer with pslverr and change nothing.
    if (rd && aligned)
    begin
      case (idx)
        `CESI_IDX_INPUT_FAIL_FLAGS:
        begin
          s_d.prdata     = {28'h0000000, s_q.input_fail};
          s_d.input_fail = 4'h0;
        end

        `CESI_IDX_LOOP_EVENT_FLAGS:
        begin
          s_d.prdata     = {28'h0000000, s_q.loop_flags};
          s_d.loop_flags = 4'h0;
        end

        `CESI_IDX_INPUT_FAIL_EN:
        begin
          s_d.prdata = {28'h0000000, s_q.input_fail_en};
        end

        `CESI_IDX_LOOP_EVENT_EN:
        begin
          s_d.prdata = {28'h0000000, s_q.loop_en};
        end

        `CESI_IDX_MON_FLAGS_HI:
        begin
          s_d.prdata = {24'h000000, s_q.mon_hi};
          s_d.mon_hi = 8'h00;
        end

        `CESI_IDX_MON_FLAGS_LO:
        begin
          s_d.prdata = {24'h000000, s_q.mon_lo};
          s_d.mon_lo = 8'h00;
        end

        `CESI_IDX_MON_MASK_HI:
        begin
          s_d.prdata = {24'h000000, s_q.mask_hi};
        end

        `CESI_IDX_MON_MASK_LO:
        begin
          s_d.prdata = {24'h000000, s_q.mask_lo};
        end

        `CESI_IDX_PIN_SELECT:
        begin
          s_d.prdata = {16'h0000, s_q.pin_sel};
        end

        default:
        begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    else if (rd)
    begin
      s_d.pslverr = 1'b1;
    end

    if (wr && aligned)
    begin
      case (idx)
        `CESI_IDX_INPUT_FAIL_EN:
        begin
          if (pstrb[0])
          begin
            s_d.input_fail_en = pwdata[3:0];
          end
        end

        `CESI_IDX_LOOP_EVENT_EN:
        begin
          if (pstrb[0])
          begin
            s_d.loop_en = pwdata[3:0];
          end
        end

        `CESI_IDX_MON_MASK_HI:
        begin
          if (pstrb[0])
          begin
            s_d.mask_hi = pwdata[7:0];
          end
        end

        `CESI_IDX_MON_MASK_LO:
        begin
          if (pstrb[0])
          begin
            s_d.mask_lo = pwdata[7:0];
          end
        end

        // Only the pin selector spans two byte lanes; every other register lives in lane 0.
        `CESI_IDX_PIN_SELECT:
        begin
          if (pstrb[0])
          begin
            s_d.pin_sel[7:0] = pwdata[7:0];
          end
          if (pstrb[1])
          begin
            s_d.pin_sel[15:8] = pwdata[15:8];
          end
        end

        // Flag registers take a write quietly and keep their contents.
        `CESI_IDX_INPUT_FAIL_FLAGS,
        `CESI_IDX_LOOP_EVENT_FLAGS,
        `CESI_IDX_MON_FLAGS_HI,
        `CESI_IDX_MON_FLAGS_LO:
        begin
          s_d.pslverr = 1'b0;
        end

        default:
        begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    else if (wr)
    begin
      s_d.pslverr = 1'b1;
    end

    // Loop events are gated by their enables before reaching the sticky flags.
    // An event held high re-sets its flag right after a clearing read, so sources should pulse.
    if (loop_a_hold_ev && s_q.loop_en[`CESI_BIT_LOOP_A_HOLD])
    begin
      s_d.loop_flags[`CESI_BIT_LOOP_A_HOLD] = 1'b1;
    end

    if (loop_a_unlock_ev && s_q.loop_en[`CESI_BIT_LOOP_A_UNLOCK])
    begin
      s_d.loop_flags[`CESI_BIT_LOOP_A_UNLOCK] = 1'b1;
    end

    if (loop_b_hold_ev && s_q.loop_en[`CESI_BIT_LOOP_B_HOLD])
    begin
      s_d.loop_flags[`CESI_BIT_LOOP_B_HOLD] = 1'b1;
    end

    if (loop_b_unlock_ev && s_q.loop_en[`CESI_BIT_LOOP_B_UNLOCK])
    begin
      s_d.loop_flags[`CESI_BIT_LOOP_B_UNLOCK] = 1'b1;
    end

    // Monitor flags take no mask at all.
    // They do not raise irq; software is expected to poll them after an input fail.
    s_d.mon_lo = s_d.mon_lo | mon_all[7:0];
    s_d.mon_hi = s_d.mon_hi | mon_all[15:8];

    s_d.input_fail = s_d.input_fail | fail_gated;

    // Request follows the next flag state, so it falls with the clearing read.
    s_d.irq = |{s_d.loop_flags, s_d.input_fail};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.pin_s1        <= '0;
      s_q.pin_s2        <= '0;
      s_q.input_fail    <= 4'(`CESI_RST_FLAGS);
      s_q.loop_flags    <= 4'(`CESI_RST_FLAGS);
      s_q.input_fail_en <= 4'(`CESI_RST_IRQ_EN);
      s_q.loop_en       <= 4'(`CESI_RST_IRQ_EN);
      s_q.mon_hi        <= `CESI_RST_FLAGS;
      s_q.mon_lo        <= `CESI_RST_FLAGS;
      // Monitor masks come up passing only the cycle and frequency indicators.
      s_q.mask_hi       <= `CESI_RST_MON_MASK;
      s_q.mask_lo       <= `CESI_RST_MON_MASK;
      s_q.pin_sel       <= `CESI_RST_PIN_SELECT;
      s_q.prdata        <= 32'h00000000;
      s_q.pready        <= 1'b0;
      s_q.pslverr       <= 1'b0;
      s_q.irq           <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq     = s_q.irq;

endmodule

/* File: tb/cesi_top_asserts.sv */
// Port assertions for the clock event status block.
`timescale 1ns/1ps
module cesi_top_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  wire take = psel && penable && !pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst; $rose(presetn) |-> !irq && !pready; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_fall; $fell(irq) |-> $past(take && !pwrite); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without read");
  property p_hold; irq && !(take && !pwrite) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_wait; take |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_busy; pready |-> $past(take); endproperty
  a_busy: assert property (p_busy) else $error("unasked answer");
  property p_idle; !psel [*2] |-> !pready; endproperty
  a_idle: assert property (p_idle) else $error("idle answer");
endmodule
bind cesi_top cesi_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .irq);

/* File: tb/cesi_host.sv */
// Host processor model: the APB master that services the block.
`timescale 1ns/1ps
module cesi_host
(
  input  wire logic            pclk,
  input  wire logic            pready,
  output logic                 psel = 1'b0,
  output logic                 penable = 1'b0,
  output logic                 pwrite = 1'b0,
  output cesi_pkg::cesi_word_t paddr = 32'h0,
  output cesi_pkg::cesi_word_t pwdata = 32'h0
);
  import cesi_pkg::*;
  // A released bus shows the inverse of the last address and write data; pwrite keeps its last value.
  task automatic xfer(input logic w, input logic [7:0] i, input cesi_word_t d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {22'h0, i, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask
endmodule

/* File: tb/test_clock_event_status_irq.sv */
// Self-checking bench of the clock event status block.
`timescale 1ns/1ps
module test_clock_event_status_irq;
  import cesi_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  cesi_word_t  paddr, pwdata, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic [11:0] gp_pin;
  cesi_nib_t   ev, cf, ff, sx, c, f, s, en, p;
  logic [32:0] notes[$];
  int          bad_count = 0;
  int          num_checks = 0;
  cesi_top DUT (.*, .loop_a_hold_ev(ev[0]), .loop_a_unlock_ev(ev[1]), .loop_b_hold_ev(ev[2]),
    .loop_b_unlock_ev(ev[3]), .cycle_fault(cf), .freq_fault(ff), .soak_expired(sx));
  cesi_host host (.*);
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i, input cesi_word_t d, input logic [32:0] e);
    notes.push_back(e);
    host.xfer(w, i, d);
  endtask
  task automatic pulse(input logic [15:0] v);
    {ev, cf, ff, sx} <= v;
    @(posedge pclk);
    {ev, cf, ff, sx} <= 16'h0;
    @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk)
    if (pready === 1'b1 && notes.size() > 0)
      chk("answer", notes.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #20000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    presetn = 1'b0;
    gp_pin = 12'h0;
    {ev, cf, ff, sx} = 16'h0;
    void'($urandom(32'h9807));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 2; i < 10; i++)
      acc(1'b0, 8'(i), 32'h0, (i > 7) ? 33'h66 : 33'h0);
    acc(1'b1, 8'h0b, 32'hf, {1'b1, 32'h0});
    pulse(16'hf000);
    acc(1'b0, 8'h03, 32'h0, 33'h0);
    acc(1'b1, 8'h05, 32'hf, 33'h0);
    for (int b = 0; b < 4; b++)
    begin
      pulse(16'h1000 << b);
      chk("irq", 33'h1, {32'h0, irq});
      acc(1'b0, 8'h03, 32'h0, 33'h1 << b);
      chk("irq", 33'h0, {32'h0, irq});
    end
    acc(1'b1, 8'h03, 32'hf, 33'h0);
    acc(1'b0, 8'h03, 32'h0, 33'h0);
    for (int k = 0; k < 4; k++)
    begin
      {c, f, s, en} = 16'($urandom);
      acc(1'b1, 8'h04, {28'h0, en}, 33'h0);
      pulse({4'h0, c, f, s});
      chk("irq", {32'h0, |(en & (c | f))}, {32'h0, irq});
      acc(1'b0, 8'h02, 32'h0, {29'h0, en & (c | f)});
      acc(1'b0, 8'h06, 32'h0, {25'h0, s[3], f[3], c[3], 1'b0, s[2], f[2], c[2], 1'b0});
      acc(1'b0, 8'h07, 32'h0, {25'h0, s[1], f[1], c[1], 1'b0, s[0], f[0], c[0], 1'b0});
    end
    p = 4'($urandom_range(11, 1));
    acc(1'b1, 8'h0a, {20'h0, p, 8'h0}, 33'h0);
    acc(1'b0, 8'h0a, 32'h0, {21'h0, p, 8'h0});
    gp_pin <= 12'h1 << p;
    @(posedge pclk);
    gp_pin <= 12'h0;
    repeat (4) @(posedge pclk);
    acc(1'b0, 8'h06, 32'h0, 33'h1);
    acc(1'b0, 8'h07, 32'h0, 33'h0);
    acc(1'b0, 8'h02, 32'h0, 33'h0);
    @(posedge pclk);
    finish_test();
  end
endmodule
